// ### srm_special_reg_move_unit.sv
// special register move unit: reads, writes, clears and sets of special registers
//
// Overview of operation
// - clear copies status, clears immediate-marked bits
// - set copies status, sets immediate-marked bits
// - user-mode clear/set not carry-only faults privileged
// - user-mode special write faults, target untouched
// - special write lands in selector's register
// - low-latency mode acknowledges 11 on enable set
// - clear/set carry immediate, others next cycle
// - full status write lands one cycle later
// - clearing interrupt enable blocks interrupts at once
// - exception/break flags block interrupts and breaks
// - clear/set touch only low fifteen or fourteen bits
// - clear/set exist only when configured
// - counter, fault, version registers are read-only
// - exception data, float, stack reads need config
// - translation reads need management and access level
// - version reads depend on version configuration
// - ident, zone, search writes need management and access level; index/entry writes need management only
// - entry writes go to indexed translation entry
// - extended read only with wide addresses
// - extended read gives fault/version upper bits
`timescale 1ns/1ps
`include "srm_defines.svh"
module srm_special_reg_move_unit
  import srm_pkg::*;
#(
  parameter int          CFG_MMU_LEVEL   = 3,
  parameter int          CFG_STATUS_INSTR = 1,
  parameter int          CFG_FPU_LEVEL   = 1,
  parameter int          CFG_TLB_ACCESS  = 3,
  parameter int          CFG_VERSION     = 2,
  parameter int          CFG_STREAM_EXC  = 1,
  parameter int          CFG_STREAM_LINKS = 1,
  parameter int          CFG_STACK_PROT  = 1,
  parameter int          CFG_INT_MODE    = 2,
  parameter int          CFG_ADDR_WIDTH  = 48,
  parameter logic [31:0] VERSION_WORD    = 32'h00000000  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire srm_req_t    req,
  input  wire logic [31:0] pcValue,
  input  wire logic [31:0] faultAddrLow,
  input  wire logic [31:0] faultAddrHigh,
  input  wire logic [31:0] excStatus,
  input  wire logic [31:0] branchSave,
  input  wire logic [31:0] excData,
  output srm_rsp_t         rsp,
  output logic [1:0]       intAck,
  output logic [31:0]      statusWord,
  output logic             intAllowed,
  output logic             brkAllowed
);

  // architectural state
  logic [31:0] status_r;
  logic [31:0] pend_r;
  logic        pendV_r;
  logic [31:0] float_r;
  logic [31:0] stkLow_r;
  logic [31:0] stkHigh_r;
  logic [31:0] procId_r;
  logic [31:0] zone_r;
  logic [31:0] tlbIdx_r;
  logic [31:0] tlbSrch_r;
  logic [31:0] translation_entry_low [`SRM_TLB_DEPTH];
  logic [31:0] translation_entry_high [`SRM_TLB_DEPTH];
  srm_rsp_t    rsp_r;
  logic [1:0]  ack_r;
  logic        intOk_r;
  logic        brkOk_r;

  // configuration decodes
  wire mmuOn     = CFG_MMU_LEVEL >= 1;
  wire mmuUser   = CFG_MMU_LEVEL > 1;
  wire clrSetOn  = CFG_STATUS_INSTR == 1;
  wire tlbRdOk   = mmuUser && (CFG_TLB_ACCESS == 1 || CFG_TLB_ACCESS == 3);
  wire tlbWrOk   = mmuUser && CFG_TLB_ACCESS > 1;
  wire stkOk     = CFG_STACK_PROT == 1;
  wire fpuOk     = CFG_FPU_LEVEL > 0;
  wire wideAddr  = CFG_ADDR_WIDTH > 32;

  // the status seen by a new operation includes bits still pending
  wire [31:0] baseStatus = pendV_r ? pend_r : status_r;
  wire        userMode   = baseStatus[`SRM_BIT_UM];
  wire        isRead     = req.valid && req.op == SRM_OP_READ;
  wire        isWrite    = req.valid && req.op == SRM_OP_WRITE;
  wire        isClrSet   = req.valid && clrSetOn &&
                           (req.op == SRM_OP_CLR || req.op == SRM_OP_SET);

  // privilege checks
  wire privClrSet = isClrSet && mmuOn && userMode &&
                    req.imm != `SRM_IMM_CARRY;
  wire privWrite  = isWrite && mmuOn && userMode;
  wire privFault  = privClrSet || privWrite;

  // immediate limited to the modifiable field
  wire [31:0] immMask = mmuOn ? `SRM_MASK_USER : `SRM_MASK_BASE;
  wire [31:0] immVal  = {17'h0, req.imm} & immMask;
  wire [31:0] clrVal  = baseStatus & ~immVal;
  wire [31:0] setVal  = baseStatus | immVal;
  wire [31:0] csVal   = (req.op == SRM_OP_CLR) ? clrVal : setVal;
  wire        doCs    = isClrSet && !privClrSet;
  wire        doWr    = isWrite && !privWrite;

  // write target decode; read-only selectors decode to no target
  wire wrStatus = doWr && req.sel == `SRM_SEL_STATUS;
  wire wrFloat  = doWr && req.sel == `SRM_SEL_FLOAT && fpuOk;
  wire wrStkLo  = doWr && req.sel == `SRM_SEL_STKLOW && stkOk;
  wire wrStkHi  = doWr && req.sel == `SRM_SEL_STKHIGH && stkOk;
  wire wrProcId = doWr && req.sel == `SRM_SEL_PROCID && tlbWrOk;
  wire wrZone   = doWr && req.sel == `SRM_SEL_ZONE && tlbWrOk;
  wire wrSrch   = doWr && req.sel == `SRM_SEL_TLBSRCH && tlbWrOk;
  wire wrTlbIdx = doWr && req.sel == `SRM_SEL_TLBIDX && mmuUser;
  wire wrTlbLo  = doWr && req.sel == `SRM_SEL_TLBLOW && mmuUser;
  wire wrTlbHi  = doWr && req.sel == `SRM_SEL_TLBHIGH && mmuUser;
  wire [`SRM_TLB_IDX_W-1:0] entSel = tlbIdx_r[`SRM_TLB_IDX_W-1:0];

  // writes that land somewhere; any other write changes nothing
  wire wrAny = wrStatus || wrFloat || wrStkLo || wrStkHi || wrProcId || wrZone ||
               wrSrch || wrTlbIdx || wrTlbLo || wrTlbHi;

  // newest status value, used for the masking guarantees
  wire [31:0] newest = doCs ? csVal : (wrStatus ? req.src : baseStatus);
  wire ieNew  = newest[`SRM_BIT_IE];
  wire busyNew = newest[`SRM_BIT_EIP] || newest[`SRM_BIT_BIP];

  // low-latency acknowledge when interrupt enable gets set
  wire ieSetByOp = (doCs && req.op == SRM_OP_SET && immVal[`SRM_BIT_IE]) ||
                   (wrStatus && req.src[`SRM_BIT_IE]);
  wire ackNow    = CFG_INT_MODE == 2 && ieSetByOp;

  // version register readout per entry
  logic [31:0] verWord [13];
  genvar gv;
  generate
    for (gv = 0; gv < 13; gv++) begin : g_ver
      assign verWord[gv] = {VERSION_WORD[31:4], 4'(gv)};
    end
  endgenerate
  wire       selVer  = req.sel[15:4] == `SRM_SEL_VER_BASE &&
                       req.sel[3:0] <= `SRM_VER_LAST;
  wire       verOk   = (req.sel[3:0] == 4'h0) ? (CFG_VERSION == 1 || CFG_VERSION == 2)
                                              : (CFG_VERSION == 2);
  wire [31:0] verData = (selVer && verOk) ? verWord[req.sel[3:0]] : 32'h0;

  // extended reads return the upper fault address part or the version word
  wire [31:0] extData = !wideAddr ? 32'h0 :
                        (req.sel == `SRM_SEL_FAULT) ? faultAddrHigh :
                        (req.sel == `SRM_SEL_VER8 ||
                         req.sel == `SRM_SEL_VER9) ? VERSION_WORD : 32'h0;

  // normal read selection, unavailable registers read as zero
  logic [31:0] normData;
  always_comb begin
    normData = 32'h0;
    case (req.sel)
      `SRM_SEL_PC:      normData = pcValue;
      `SRM_SEL_STATUS:  normData = baseStatus;
      `SRM_SEL_FAULT:   normData = faultAddrLow;
      `SRM_SEL_EXCSTAT: normData = excStatus;
      `SRM_SEL_FLOAT:   normData = fpuOk ? float_r : 32'h0;
      `SRM_SEL_BTSAVE:  normData = branchSave;
      `SRM_SEL_EXCDATA: normData = (CFG_STREAM_EXC == 1 && CFG_STREAM_LINKS > 0)
                                   ? excData : 32'h0;
      `SRM_SEL_STKLOW:  normData = stkOk ? stkLow_r : 32'h0;
      `SRM_SEL_STKHIGH: normData = stkOk ? stkHigh_r : 32'h0;
      `SRM_SEL_PROCID:  normData = tlbRdOk ? procId_r : 32'h0;
      `SRM_SEL_ZONE:    normData = tlbRdOk ? zone_r : 32'h0;
      `SRM_SEL_TLBIDX:  normData = (mmuUser && CFG_TLB_ACCESS > 0) ? tlbIdx_r : 32'h0;
      `SRM_SEL_TLBLOW:  normData = tlbRdOk ? translation_entry_low[entSel] : 32'h0;
      `SRM_SEL_TLBHIGH: normData = tlbRdOk ? translation_entry_high[entSel] : 32'h0;
      default:          normData = verData;
    endcase
  end

  // answer of this operation
  srm_rsp_t rsp_nxt;
  always_comb begin
    rsp_nxt          = '0;
    rsp_nxt.rdValid  = (isRead || doCs);
    rsp_nxt.rdData   = isRead ? (req.ext ? extData : normData) : baseStatus;
    rsp_nxt.excValid = privFault;
    rsp_nxt.excCause = privFault ? `SRM_CAUSE_PRIV : 5'h0;
  end

  // status word: clear/set carry now, other bits one cycle later
  logic [31:0] status_nxt;
  always_comb begin
    status_nxt = baseStatus;
    if (doCs) begin
      status_nxt[`SRM_BIT_CARRY] = csVal[`SRM_BIT_CARRY];
    end
  end

  // status state and pending update
  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= `SRM_STATUS_RST;
      pend_r   <= `SRM_STATUS_RST;
      pendV_r  <= 1'b0;
    end else begin
      status_r <= status_nxt;
      pendV_r  <= doCs || wrStatus;
      pend_r   <= doCs ? csVal : req.src;
    end
  end

  // plain special registers
  always_ff @(posedge clk) begin
    if (reset) begin
      float_r   <= 32'h0;
      stkLow_r  <= 32'h0;
      stkHigh_r <= 32'h0;
      procId_r  <= 32'h0;
      zone_r    <= 32'h0;
      tlbIdx_r  <= 32'h0;
      tlbSrch_r <= 32'h0;
    end else begin
      if (wrFloat)  float_r   <= req.src;
      if (wrStkLo)  stkLow_r  <= req.src;
      if (wrStkHi)  stkHigh_r <= req.src;
      if (wrProcId) procId_r  <= req.src;
      if (wrZone)   zone_r    <= req.src;
      if (wrTlbIdx) tlbIdx_r  <= req.src;
      if (wrSrch)   tlbSrch_r <= req.src;
    end
  end

  // translation entries, written through the current index
  always_ff @(posedge clk) begin
    if (wrTlbLo) translation_entry_low[entSel] <= req.src;
    if (wrTlbHi) translation_entry_high[entSel] <= req.src;
  end

  // answer, acknowledge and masking outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_r   <= '0;
      ack_r   <= `SRM_ACK_IDLE;
      intOk_r <= 1'b0;
      brkOk_r <= 1'b1;
    end else begin
      rsp_r   <= rsp_nxt;
      ack_r   <= ackNow ? `SRM_ACK_SET : `SRM_ACK_IDLE;
      intOk_r <= ieNew && !busyNew;
      brkOk_r <= !busyNew;
    end
  end

  assign rsp        = rsp_r;
  assign intAck     = ack_r;
  assign statusWord = status_r;
  assign intAllowed = intOk_r;
  assign brkAllowed = brkOk_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CLR_RESULT: assert property (doCs && req.op == SRM_OP_CLR |=>
    statusWord[`SRM_BIT_CARRY] == $past(clrVal[`SRM_BIT_CARRY]) &&
    rsp.rdData == $past(baseStatus))
    else $error("clear result wrong");
  AST_SET_LATE: assert property (doCs && req.op == SRM_OP_SET |=> ##1
    statusWord == $past(setVal, 2))
    else $error("set not applied");
  AST_PRIV_CS: assert property (privClrSet |=> rsp.excValid &&
    rsp.excCause == 5'b00111 && !rsp.rdValid)
    else $error("privileged clear/set missed");
  AST_PRIV_WR: assert property (privWrite |=> rsp.excValid &&
    rsp.excCause == `SRM_CAUSE_PRIV && $stable(float_r) && $stable(stkLow_r))
    else $error("privileged write not blocked");
  AST_STATUS_WR: assert property (wrStatus && !doCs |=>
    statusWord == $past(baseStatus) ##1 statusWord == $past(req.src, 2))
    else $error("status write timing wrong");
  AST_ACK: assert property (ackNow |=> intAck == 2'b11 ##1
    (intAck == 2'b11) == $past(ackNow))
    else $error("acknowledge wrong");
  AST_IE_CLEAR: assert property (doCs && req.op == SRM_OP_CLR &&
    immVal[`SRM_BIT_IE] |=> !intAllowed)
    else $error("interrupt not blocked");
  AST_BUSY_SET: assert property (doCs && req.op == SRM_OP_SET &&
    (immVal[`SRM_BIT_EIP] || immVal[`SRM_BIT_BIP]) |=> !intAllowed && !brkAllowed)
    else $error("break not blocked");
  AST_IMM_FIELD: assert property (doCs |=> ##1
    statusWord[31:15] == $past(baseStatus[31:15], 2))
    else $error("upper status bits touched");
  AST_NO_TARGET: assert property (doWr && req.sel == `SRM_SEL_PC |=>
    !rsp.excValid && $stable(tlbIdx_r) && $stable(float_r))
    else $error("read-only selector changed state");

  // status clear/set: answer now, carry now, the rest a cycle later
  AST_SET_CARRY: assert property (doCs && req.op == SRM_OP_SET |=>
    statusWord[`SRM_BIT_CARRY] == $past(setVal[`SRM_BIT_CARRY]))
    else $error("carry not set at once");
  AST_SET_RDATA: assert property (doCs && req.op == SRM_OP_SET |=>
    rsp.rdValid && rsp.rdData == $past(baseStatus))
    else $error("set returned wrong word");
  AST_CLR_LATE: assert property (doCs && req.op == SRM_OP_CLR |=> ##1
    statusWord == $past(clrVal, 2))
    else $error("clear not applied");
  AST_CARRY_USER: assert property (isClrSet && mmuOn && userMode &&
    req.imm == `SRM_IMM_CARRY |=> rsp.rdValid && !rsp.excValid)
    else $error("carry-only op refused in user mode");

  // refused ops leave the acknowledge idle and change no state
  AST_PRIV_NO_ACK: assert property (privFault |=> intAck == `SRM_ACK_IDLE &&
    !rsp.rdValid)
    else $error("refused op acknowledged");
  AST_PRIV_CS_KEEP: assert property (privClrSet |=> !pendV_r &&
    statusWord == $past(baseStatus))
    else $error("refused clear/set changed status");
  AST_PRIV_WR_KEEP: assert property (privWrite |=> !pendV_r &&
    $stable(stkHigh_r) && $stable(tlbIdx_r) && $stable(zone_r))
    else $error("refused write changed state");

  // permitted writes land in the selected register
  AST_WR_FLOAT: assert property (wrFloat |=> float_r == $past(req.src))
    else $error("float status not written");
  AST_WR_STKLOW: assert property (wrStkLo |=> stkLow_r == $past(req.src))
    else $error("low stack limit not written");
  AST_WR_STKHIGH: assert property (wrStkHi |=> stkHigh_r == $past(req.src))
    else $error("high stack limit not written");
  AST_WR_INDEX: assert property (wrTlbIdx |=> tlbIdx_r == $past(req.src))
    else $error("translation index not written");
  AST_WR_PROCID: assert property (wrProcId |=> procId_r == $past(req.src))
    else $error("process ident not written");
  AST_WR_ZONE: assert property (wrZone |=> zone_r == $past(req.src))
    else $error("zone protection not written");
  AST_WR_SEARCH: assert property (wrSrch |=> tlbSrch_r == $past(req.src))
    else $error("search index not written");
  AST_ENTRY_LOW: assert property (wrTlbLo |=> translation_entry_low[entSel] == $past(req.src))
    else $error("low entry not written at index");
  AST_ENTRY_HIGH: assert property (wrTlbHi |=> translation_entry_high[entSel] == $past(req.src))
    else $error("high entry not written at index");
  AST_NO_MATCH: assert property (doWr && !wrAny |=>
    !rsp.rdValid && !rsp.excValid && !pendV_r && $stable(float_r) &&
    $stable(stkLow_r) && $stable(stkHigh_r) && $stable(procId_r) && $stable(zone_r) &&
    $stable(tlbIdx_r) && $stable(tlbSrch_r))
    else $error("unmatched write changed state");

  // full status writes drive the masking and acknowledge outputs
  AST_WR_MASK_IE: assert property (wrStatus && !req.src[`SRM_BIT_IE] |=>
    !intAllowed)
    else $error("interrupt not blocked by write");
  AST_WR_MASK_BUSY: assert property (wrStatus && (req.src[`SRM_BIT_EIP] ||
    req.src[`SRM_BIT_BIP]) |=> !intAllowed && !brkAllowed)
    else $error("break not blocked by write");
  AST_WR_ACK: assert property (CFG_INT_MODE == 2 && wrStatus &&
    req.src[`SRM_BIT_IE] |=> intAck == `SRM_ACK_SET)
    else $error("write did not acknowledge");
  AST_ACK_IDLE: assert property (!ackNow |=> intAck == `SRM_ACK_IDLE)
    else $error("acknowledge without enable set");

  // reads answer next cycle with the selected word
  AST_RD_ANSWER: assert property (isRead |=> rsp.rdValid && !rsp.excValid)
    else $error("read not answered");
  AST_RD_STATUS: assert property (isRead && !req.ext &&
    req.sel == `SRM_SEL_STATUS |=> rsp.rdData == $past(baseStatus))
    else $error("status read misses pending bits");
  AST_RD_PC: assert property (isRead && !req.ext && req.sel == `SRM_SEL_PC |=>
    rsp.rdData == $past(pcValue))
    else $error("counter read wrong");
  AST_EXT_FAULT: assert property (isRead && req.ext && wideAddr &&
    req.sel == `SRM_SEL_FAULT |=> rsp.rdData == $past(faultAddrHigh))
    else $error("extended fault read wrong");

endmodule

// ### srm_defines.svh
// offsets, field positions, reset values and codes for the special register move unit
`ifndef SRM_DEFINES_SVH
`define SRM_DEFINES_SVH
`define SRM_SEL_PC       16'h0000
`define SRM_SEL_STATUS   16'h0001
`define SRM_SEL_FAULT    16'h0003
`define SRM_SEL_EXCSTAT  16'h0005
`define SRM_SEL_FLOAT    16'h0007
`define SRM_SEL_BTSAVE   16'h000b
`define SRM_SEL_EXCDATA  16'h000d
`define SRM_SEL_STKLOW   16'h0800
`define SRM_SEL_STKHIGH  16'h0802
`define SRM_SEL_PROCID   16'h1000
`define SRM_SEL_ZONE     16'h1001
`define SRM_SEL_TLBIDX   16'h1002
`define SRM_SEL_TLBLOW   16'h1003
`define SRM_SEL_TLBHIGH  16'h1004
`define SRM_SEL_TLBSRCH  16'h1005
`define SRM_SEL_VER_BASE 12'h200
`define SRM_VER_LAST     4'hc
`define SRM_SEL_VER8     16'h2008
`define SRM_SEL_VER9     16'h2009
`define SRM_BIT_CARRY    2
`define SRM_BIT_IE       1
`define SRM_BIT_BIP      3
`define SRM_BIT_EIP      8
`define SRM_BIT_UM       11
`define SRM_BIT_VM       13
`define SRM_IMM_CARRY    15'h0004
`define SRM_MASK_USER    32'h00007fff
`define SRM_MASK_BASE    32'h00003fff
`define SRM_CAUSE_PRIV   5'b00111
`define SRM_ACK_SET      2'b11
`define SRM_ACK_IDLE     2'b00
`define SRM_STATUS_RST   32'h00000000
`define SRM_TLB_IDX_W    6
`define SRM_TLB_DEPTH    64
`endif

// ### srm_pkg.sv
// types shared by the special register move unit
package srm_pkg;
  typedef enum logic [3:0] {
    SRM_OP_READ  = 4'b0001,
    SRM_OP_WRITE = 4'b0010,
    SRM_OP_CLR   = 4'b0100,
    SRM_OP_SET   = 4'b1000
  } srm_op_t;
  typedef struct packed {
    logic        valid;
    srm_op_t     op;
    logic [15:0] sel;
    logic        ext;
    logic [14:0] imm;
    logic [31:0] src;
  } srm_req_t;
  typedef struct packed {
    logic        rdValid;
    logic [31:0] rdData;
    logic        excValid;
    logic [4:0]  excCause;
  } srm_rsp_t;
endpackage

// ### tb_top.sv
// self-checking bench for the special register move unit
`timescale 1ns/1ps
`include "srm_defines.svh"
module tb_top;
  import srm_pkg::*;
  logic        clk;
  logic        reset;
  srm_req_t    req;
  logic [31:0] pcValue;
  logic [31:0] faultAddrLow;
  logic [31:0] faultAddrHigh;
  logic [31:0] excStatus;
  logic [31:0] branchSave;
  logic [31:0] excData;
  srm_rsp_t    rsp;
  logic [1:0]  intAck;
  logic [31:0] statusWord;
  logic        intAllowed;
  logic        brkAllowed;
  int          num_errors;
  int          checked;
  logic [15:0] rwSel [6];
  logic [15:0] roSel [6];

  srm_special_reg_move_unit u_srm_special_reg_move_unit (
    .clk           (clk),
    .reset         (reset),
    .req           (req),
    .pcValue       (pcValue),
    .faultAddrLow  (faultAddrLow),
    .faultAddrHigh (faultAddrHigh),
    .excStatus     (excStatus),
    .branchSave    (branchSave),
    .excData       (excData),
    .rsp           (rsp),
    .intAck        (intAck),
    .statusWord    (statusWord),
    .intAllowed    (intAllowed),
    .brkAllowed    (brkAllowed)
  );

  // core clock, 40 ns period
  always #20 clk = ~clk;

  // compare one value, count and report
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one op: presented after an edge, taken at the next, answer sampled just after it;
  // the idle edge before each op keeps status reads clear of the last update
  task automatic doOp(srm_op_t o, logic [15:0] s, logic e, logic [14:0] i, logic [31:0] d);
    @(posedge clk);
    #1;
    req.valid = 1'b1;
    req.op    = o;
    req.sel   = s;
    req.ext   = e;
    req.imm   = i;
    req.src   = d;
    @(posedge clk);
    #1;
    req.valid = 1'b0;
  endtask

  // read a selector and compare the returned word
  task automatic rd(logic [15:0] s, logic e, logic [31:0] exp);
    doOp(SRM_OP_READ, s, e, 15'h0000, 32'h00000000);
    chk({31'h0, rsp.rdValid}, 32'h1);
    chk(rsp.rdData, exp);
  endtask

  // let one more cycle pass, sampling after the edge
  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  // main sequence
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    req = '0;
    pcValue = 32'h00000400;
    faultAddrLow = 32'h0000a5a0;
    faultAddrHigh = 32'h0000beef;
    excStatus = 32'h00000027;
    branchSave = 32'h00000810;
    excData = 32'h0000c0de;
    num_errors = 0;
    checked = 0;
    rwSel = '{`SRM_SEL_FLOAT, `SRM_SEL_STKLOW, `SRM_SEL_STKHIGH, `SRM_SEL_PROCID,
              `SRM_SEL_ZONE, `SRM_SEL_TLBIDX};
    roSel = '{`SRM_SEL_PC, `SRM_SEL_EXCSTAT, `SRM_SEL_FAULT, `SRM_SEL_BTSAVE,
              `SRM_SEL_EXCDATA, 16'h0abc};
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    chk(statusWord, 32'h0);
    chk({31'h0, brkAllowed}, 32'h1);
    // full status write: enable lands a cycle later, acknowledge at once
    doOp(SRM_OP_WRITE, `SRM_SEL_STATUS, 1'b0, 15'h0000, 32'h00000002);
    chk(statusWord, 32'h0);
    chk({30'h0, intAck}, 32'h3);
    step();
    chk(statusWord, 32'h2);
    chk({31'h0, intAllowed}, 32'h1);
    rd(`SRM_SEL_STATUS, 1'b0, 32'h2);
    // carry set is immediate
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0004, 32'h0);
    chk(rsp.rdData, 32'h2);
    chk(statusWord, 32'h6);
    // enable clear: old word returned, masking at once, bit one cycle later
    doOp(SRM_OP_CLR, `SRM_SEL_STATUS, 1'b0, 15'h0002, 32'h0);
    chk(rsp.rdData, 32'h6);
    chk(statusWord, 32'h6);
    chk({31'h0, intAllowed}, 32'h0);
    chk({30'h0, intAck}, 32'h0);
    step();
    chk(statusWord, 32'h4);
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0002, 32'h0);
    chk({30'h0, intAck}, 32'h3);
    // break and exception flags mask interrupts and breaks
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0008, 32'h0);
    chk({30'h0, intAllowed, brkAllowed}, 32'h0);
    doOp(SRM_OP_CLR, `SRM_SEL_STATUS, 1'b0, 15'h0008, 32'h0);
    chk({30'h0, intAllowed, brkAllowed}, 32'h3);
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0100, 32'h0);
    chk({30'h0, intAllowed, brkAllowed}, 32'h0);
    doOp(SRM_OP_CLR, `SRM_SEL_STATUS, 1'b0, 15'h0102, 32'h0);
    step();
    chk(statusWord, 32'h4);
    // full writes with the exception flag, then back: masking follows the newest word
    doOp(SRM_OP_WRITE, `SRM_SEL_STATUS, 1'b0, 15'h0000, 32'h00000104);
    chk({30'h0, intAllowed, brkAllowed}, 32'h0);
    doOp(SRM_OP_WRITE, `SRM_SEL_STATUS, 1'b0, 15'h0000, 32'h00000004);
    chk({30'h0, intAllowed, brkAllowed}, 32'h1);
    step();
    chk(statusWord, 32'h4);
    // writable registers, index written last; the idle edge after an ident write
    // stands in for the synchronizing branch
    for (int k = 0; k < 6; k++) begin
      doOp(SRM_OP_WRITE, rwSel[k], 1'b0, 15'h0000, (k == 5) ? 32'h5 : {rwSel[k], 16'h5a00});
      chk({30'h0, rsp.rdValid, rsp.excValid}, 32'h0);
    end
    for (int k = 0; k < 6; k++) begin
      rd(rwSel[k], 1'b0, (k == 5) ? 32'h5 : {rwSel[k], 16'h5a00});
    end
    // entries follow the index; idle edge after a high write serves as fence
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBLOW, 1'b0, 15'h0000, 32'h000000ab);
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBHIGH, 1'b0, 15'h0000, 32'h000000cd);
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBIDX, 1'b0, 15'h0000, 32'h6);
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBLOW, 1'b0, 15'h0000, 32'h00000012);
    rd(`SRM_SEL_TLBLOW, 1'b0, 32'h00000012);
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBIDX, 1'b0, 15'h0000, 32'h5);
    rd(`SRM_SEL_TLBLOW, 1'b0, 32'h000000ab);
    rd(`SRM_SEL_TLBHIGH, 1'b0, 32'h000000cd);
    doOp(SRM_OP_WRITE, `SRM_SEL_TLBSRCH, 1'b0, 15'h0000, 32'h00000033);
    chk({30'h0, rsp.rdValid, rsp.excValid}, 32'h0);
    // read-only and unmatched targets ignore writes silently
    for (int k = 0; k < 6; k++) begin
      doOp(SRM_OP_WRITE, roSel[k], 1'b0, 15'h0000, 32'hffffffff);
      chk({30'h0, rsp.rdValid, rsp.excValid}, 32'h0);
    end
    rd(`SRM_SEL_PC, 1'b0, pcValue);
    rd(`SRM_SEL_EXCSTAT, 1'b0, excStatus);
    rd(`SRM_SEL_FAULT, 1'b0, faultAddrLow);
    rd(`SRM_SEL_BTSAVE, 1'b0, branchSave);
    rd(`SRM_SEL_EXCDATA, 1'b0, excData);
    rd(16'h200c, 1'b0, 32'h0000000c);
    rd(`SRM_SEL_FAULT, 1'b1, faultAddrHigh);
    rd(`SRM_SEL_VER8, 1'b1, 32'h0);
    // enter user mode, then privileged attempts are refused
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0800, 32'h0);
    step();
    chk(statusWord, 32'h00000804);
    doOp(SRM_OP_SET, `SRM_SEL_STATUS, 1'b0, 15'h0002, 32'h0);
    chk({25'h0, rsp.rdValid, rsp.excValid, rsp.excCause}, 32'h27);
    doOp(SRM_OP_CLR, `SRM_SEL_STATUS, 1'b0, 15'h0004, 32'h0);
    chk({25'h0, rsp.rdValid, rsp.excValid, rsp.excCause}, 32'h40);
    chk(statusWord, 32'h00000800);
    doOp(SRM_OP_WRITE, `SRM_SEL_STKLOW, 1'b0, 15'h0000, 32'h0);
    chk({25'h0, rsp.rdValid, rsp.excValid, rsp.excCause}, 32'h27);
    rd(`SRM_SEL_STKLOW, 1'b0, {`SRM_SEL_STKLOW, 16'h5a00});
    report_and_stop();
  end
endmodule
